// [src/glue_and_strap_logic.sv]
// What this block does
// RULE1 - LED pulled low while any of the three drive inputs is low.
// RULE2 - Supply request driven low for on, released high for off.
// RULE3 - Power-good out only with supply good and panel button released.
// RULE4 - Low on panel reset input means button pressed.
// RULE5 - Low on processor-present input means a processor is installed.
// RULE6 - Socket clock gate disables socket clock when supply not valid.
// RULE7 - Base strap high gives 2Eh-2Fh, low gives 4Eh-4Fh.
// RULE8 - Float strap low at power-up floats all outputs.
// RULE9 - Test strap low at power-up selects XOR tree mode.
// RULE10 - XOR tree of all pins presented on the tree output; code trees synced inputs, shared port and supply request, not straps.
// RULE11 - Board never straps float and test low together.
// RULE12 - Codec enable shares the pin with general-purpose port 14.
// RULE13 - Straps captured at power-up reset and held afterward.
// RULE14 - Asynchronous inputs synchronised before use.
`timescale 1ns/1ps
`include "glue_params.svh"
module glue_and_strap_logic (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_supply_on_req,
	input wire logic i_supply_good_in,
	input wire logic i_panel_button_reset_n,
	input wire logic i_cpu_present_n,
	input wire logic i_primary_drive_busy_n,
	input wire logic i_secondary_drive_busy_n,
	input wire logic i_scsi_drive_busy_n,
	input wire logic i_cfg_base_select_strap,
	input wire logic i_float_all_strap_n,
	input wire logic i_xor_test_strap_n,
	input wire logic i_shared_gp_port,
	input wire logic i_shared_gp_port_oe_n,
	output logic o_drive_activity_led_n,
	output logic o_drive_activity_led_oe_n,
	output logic o_main_supply_request_n,
	output logic o_main_supply_request_oe_n,
	output logic o_system_good_out,
	output logic o_system_good_out_oe_n,
	output logic o_socket_clock_gate,
	output logic o_socket_clock_gate_oe_n,
	output logic o_cpu_installed,
	output logic o_codec_enable_in,
	output logic o_shared_gp_port_out,
	output logic o_shared_gp_port_oe_n,
	output logic [7:0] o_cfg_index_addr,
	output logic [7:0] o_cfg_data_addr,
	output glue_pkg::pin_mode_t o_pin_mode,
	output logic o_straps_valid,
	output logic o_xor_tree_out
);
	import glue_pkg::*;

	//--------------------------------------------------------------
	// Input synchronisation and strap capture
	//--------------------------------------------------------------
	glue_sync_if sync_bus ();
	logic [`IN_COUNT-1:0] in_s;
	logic [`STRAP_COUNT-1:0] straps;
	logic straps_done;
	logic supply_req_s1_q;
	logic supply_req_s2_q;
	logic gp_s1_q;
	logic gp_s2_q;

	// Pack the asynchronous pins for the synchroniser
	assign sync_bus.raw = {i_scsi_drive_busy_n, i_secondary_drive_busy_n,
		i_primary_drive_busy_n, i_cpu_present_n, i_panel_button_reset_n,
		i_supply_good_in};
	assign in_s = sync_bus.synced; // see RULE14

	glue_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(sync_bus)
	);

	strap_capture u_straps (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_straps({i_xor_test_strap_n, i_float_all_strap_n, i_cfg_base_select_strap}),
		.o_captured(straps),
		.o_done(straps_done)
	);

	// Supply request and shared port come from other logic domains
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			supply_req_s1_q <= 1'b0;
			supply_req_s2_q <= 1'b0;
			gp_s1_q <= 1'b1;
			gp_s2_q <= 1'b1;
		end else begin
			supply_req_s1_q <= i_supply_on_req;
			supply_req_s2_q <= supply_req_s1_q;
			gp_s1_q <= i_shared_gp_port;
			gp_s2_q <= gp_s1_q;
		end
	end

	//--------------------------------------------------------------
	// Functional values and pin mode
	//--------------------------------------------------------------
	logic led_n;
	logic supply_req_n;
	logic sys_good;
	logic sock_gate;
	logic float_mode;
	logic xor_mode;
	logic xor_d;

	// Any active-low drive input lights the LED
	assign led_n = in_s[`IN_PRIMARY_N] & in_s[`IN_SECONDARY_N]
		& in_s[`IN_SCSI_N]; // see RULE1
	// Active low means on
	assign supply_req_n = ~supply_req_s2_q; // see RULE2
	// Button pressed is a low level and blocks power-good
	assign sys_good = in_s[`IN_SUPPLY_GOOD] & in_s[`IN_PANEL_RESET_N]; // see RULE3 see RULE4
	// Gate high enables the socket clock; low whenever supply invalid
	assign sock_gate = in_s[`IN_SUPPLY_GOOD]; // see RULE6

	// Float wins if the board breaks the strap pairing
	assign float_mode = ~straps[`STRAP_FLOAT_N]; // see RULE8 see RULE11
	assign xor_mode = ~straps[`STRAP_TEST_N] & ~float_mode; // see RULE9

	// Tree of the synced inputs, shared port and supply request (no straps), sampled through synchronisers
	assign xor_d = ^{in_s, gp_s2_q, supply_req_s2_q}; // see RULE10

	//--------------------------------------------------------------
	// Registered outputs
	//--------------------------------------------------------------
	// Pin values; open-drain pins drive low only via enable
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_drive_activity_led_n <= `RST_LED_N;
			o_main_supply_request_n <= `RST_SUPPLY_REQ_N;
			o_system_good_out <= 1'b0;
			o_socket_clock_gate <= 1'b0;
			o_cpu_installed <= 1'b0;
			o_codec_enable_in <= 1'b1;
			o_shared_gp_port_out <= 1'b1;
			o_xor_tree_out <= 1'b0;
		end else begin
			o_drive_activity_led_n <= led_n;
			o_main_supply_request_n <= supply_req_n;
			o_system_good_out <= sys_good;
			o_socket_clock_gate <= sock_gate;
			o_cpu_installed <= ~in_s[`IN_CPU_PRESENT_N]; // see RULE5
			o_codec_enable_in <= gp_s2_q; // see RULE12
			o_shared_gp_port_out <= gp_s2_q;
			o_xor_tree_out <= xor_mode & xor_d; // see RULE10
		end
	end

	// Output enables (low = driving); float releases all
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_drive_activity_led_oe_n <= 1'b1;
			o_main_supply_request_oe_n <= 1'b1;
			o_system_good_out_oe_n <= 1'b1;
			o_socket_clock_gate_oe_n <= 1'b1;
			o_shared_gp_port_oe_n <= 1'b1;
		end else if (float_mode || !straps_done) begin // see RULE8
			o_drive_activity_led_oe_n <= 1'b1;
			o_main_supply_request_oe_n <= 1'b1;
			o_system_good_out_oe_n <= 1'b1;
			o_socket_clock_gate_oe_n <= 1'b1;
			o_shared_gp_port_oe_n <= 1'b1;
		end else begin
			// Open-drain LED, supply request and gate: enable only when pulling low; good out always driven
			o_drive_activity_led_oe_n <= led_n;
			o_main_supply_request_oe_n <= supply_req_n; // see RULE2
			o_system_good_out_oe_n <= 1'b0;
			o_socket_clock_gate_oe_n <= sock_gate; // see RULE6
			o_shared_gp_port_oe_n <= i_shared_gp_port_oe_n;
		end
	end

	// Captured configuration, held until next reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cfg_index_addr <= `CFG_BASE_HIGH;
			o_cfg_data_addr <= `CFG_BASE_HIGH + 8'h01;
			o_pin_mode <= PIN_NORMAL;
			o_straps_valid <= 1'b0;
		end else begin
			o_straps_valid <= straps_done; // see RULE13
			if (straps[`STRAP_BASE]) begin // see RULE7
				o_cfg_index_addr <= `CFG_BASE_HIGH;
				o_cfg_data_addr <= `CFG_BASE_HIGH + 8'h01;
			end else begin
				o_cfg_index_addr <= `CFG_BASE_LOW;
				o_cfg_data_addr <= `CFG_BASE_LOW + 8'h01;
			end
			if (float_mode) begin
				o_pin_mode <= PIN_FLOAT;
			end else if (xor_mode) begin
				o_pin_mode <= PIN_XOR_TREE;
			end else begin
				o_pin_mode <= PIN_NORMAL;
			end
		end
	end
endmodule

// [src/glue_params.svh]
`ifndef GLUE_PARAMS_SVH
`define GLUE_PARAMS_SVH

// Configuration index/data pair bases
`define CFG_BASE_HIGH 8'h2E
`define CFG_BASE_LOW 8'h4E
// Input vector field positions
`define IN_SUPPLY_GOOD 0
`define IN_PANEL_RESET_N 1
`define IN_CPU_PRESENT_N 2
`define IN_PRIMARY_N 3
`define IN_SECONDARY_N 4
`define IN_SCSI_N 5
`define IN_COUNT 6
// Strap vector positions and width
`define STRAP_BASE 0
`define STRAP_FLOAT_N 1
`define STRAP_TEST_N 2
`define STRAP_COUNT 3
// Reset values of the output flops
`define RST_LED_N 1'b1
`define RST_SUPPLY_REQ_N 1'b1

`endif

// [src/glue_pkg.sv]
package glue_pkg;
	typedef enum logic [2:0] {
		PIN_NORMAL = 3'b001,
		PIN_FLOAT = 3'b010,
		PIN_XOR_TREE = 3'b100
	} pin_mode_t;
endpackage

// [src/glue_sync_if.sv]
`timescale 1ns/1ps
interface glue_sync_if;
	logic [5:0] raw;
	logic [5:0] synced;
	modport src (output raw, input synced);
	modport sync (input raw, output synced);
endinterface

// [src/glue_sync.sv]
`timescale 1ns/1ps
`include "glue_params.svh"
module glue_sync (
	input wire logic i_clk,
	input wire logic i_rst_n,
	glue_sync_if.sync bus
);
	logic [`IN_COUNT-1:0] meta_q;
	logic [`IN_COUNT-1:0] sync_q;

	// Two-stage synchroniser per input; reset to inactive levels
	genvar g;
	generate
		for (g = 0; g < `IN_COUNT; g++) begin : g_bit
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta_q[g] <= (g == `IN_SUPPLY_GOOD) ? 1'b0 : 1'b1;
					sync_q[g] <= (g == `IN_SUPPLY_GOOD) ? 1'b0 : 1'b1;
				end else begin
					meta_q[g] <= bus.raw[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign bus.synced = sync_q;
endmodule

// [src/strap_capture.sv]
`timescale 1ns/1ps
`include "glue_params.svh"
module strap_capture (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [`STRAP_COUNT-1:0] i_straps,
	output logic [`STRAP_COUNT-1:0] o_captured,
	output logic o_done
);
	logic [`STRAP_COUNT-1:0] meta_q;
	logic [`STRAP_COUNT-1:0] sync_q;
	logic [`STRAP_COUNT-1:0] cap_q;
	logic [1:0] armed_q;
	logic done_q;

	// Synchronise strap pins; reset value mirrors pull-up default
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= 3'h7;
			sync_q <= 3'h7;
		end else begin
			meta_q <= i_straps;
			sync_q <= meta_q;
		end
	end

	// Two-cycle arm so the reset value has left the sync pipe before the latch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			armed_q <= 2'h0;
			done_q <= 1'b0;
			cap_q <= 3'h7;
		end else begin
			armed_q <= {armed_q[0], 1'b1};
			if (armed_q[1] && !done_q) begin
				cap_q <= sync_q;
				done_q <= 1'b1;
			end
		end
	end

	assign o_captured = cap_q;
	assign o_done = done_q;
endmodule

// [verification/glue_props.sv]
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module glue_props (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_supply_on_req,
	input wire logic i_supply_good_in,
	input wire logic i_panel_button_reset_n,
	input wire logic i_cpu_present_n,
	input wire logic i_primary_drive_busy_n,
	input wire logic i_secondary_drive_busy_n,
	input wire logic i_scsi_drive_busy_n,
	input wire logic o_drive_activity_led_n,
	input wire logic o_drive_activity_led_oe_n,
	input wire logic o_main_supply_request_n,
	input wire logic o_system_good_out,
	input wire logic o_system_good_out_oe_n,
	input wire logic o_socket_clock_gate,
	input wire logic o_cpu_installed,
	input wire logic [7:0] o_cfg_index_addr,
	input wire logic [7:0] o_cfg_data_addr,
	input wire glue_pkg::pin_mode_t o_pin_mode,
	input wire logic o_straps_valid
);
	import glue_pkg::*;
	logic run;
	// Judge levels only once the sync pipe holds post-capture samples
	assign run = o_straps_valid && o_pin_mode == PIN_NORMAL;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_boot;
		!o_straps_valid [*3];
	endsequence
	sequence s_armed;
		run && $past(o_straps_valid, 3);
	endsequence
	chk_led_any_drive: assert property (s_armed |-> o_drive_activity_led_n ==
		&$past({i_primary_drive_busy_n, i_secondary_drive_busy_n, i_scsi_drive_busy_n}, 3))
		else $error("led level wrong");
	chk_led_open_drain: assert property (run |-> o_drive_activity_led_oe_n == o_drive_activity_led_n)
		else $error("led enable wrong");
	chk_supply_req: assert property (s_armed |-> o_main_supply_request_n == !$past(i_supply_on_req, 3))
		else $error("supply request wrong");
	chk_good_out: assert property (s_armed |-> o_system_good_out ==
		$past(i_supply_good_in && i_panel_button_reset_n, 3)) else $error("good out wrong");
	chk_cpu_flag: assert property (s_armed |-> o_cpu_installed == !$past(i_cpu_present_n, 3))
		else $error("cpu flag wrong");
	chk_gate_off: assert property (!$past(i_supply_good_in, 3) |-> !o_socket_clock_gate)
		else $error("socket clock not gated");
	chk_addr_pair: assert property (o_straps_valid |-> o_cfg_data_addr == o_cfg_index_addr + 8'h01
		&& (o_cfg_index_addr == 8'h2E || o_cfg_index_addr == 8'h4E)) else $error("address pair wrong");
	chk_float_pins: assert property (o_pin_mode == PIN_FLOAT |-> o_drive_activity_led_oe_n
		&& o_system_good_out_oe_n) else $error("pin driven while floating");
	chk_strap_hold: assert property (o_straps_valid && $past(o_straps_valid) |->
		$stable(o_pin_mode) && $stable(o_cfg_index_addr)) else $error("strap setting moved");
	chk_boot_capture: assert property ($rose(i_rst_n) |-> s_boot ##[1:3] o_straps_valid)
		else $error("straps not captured");
endmodule
bind glue_and_strap_logic glue_props u_props (.*);

// [verification/board_model.sv]
`timescale 1ns/1ps
// ----------
// Supply and strap resistors
// ----------
module board_model (
	input wire logic i_clk,
	input wire logic i_req_n,
	input wire logic [1:0] i_strap_sel,
	output logic o_supply_good,
	output logic o_float_n,
	output logic o_test_n
);
	logic [3:0] cnt_q;
	// Supply ramps for a while after the request, drops at once on release
	always_ff @(posedge i_clk) begin
		cnt_q <= i_req_n ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
	end
	assign o_supply_good = cnt_q > 4'h5;
	// Board never pulls both test straps low
	assign o_float_n = i_strap_sel != 2'h1;
	assign o_test_n = i_strap_sel != 2'h2;
endmodule

// [verification/glue_and_strap_logic_tb_top.sv]
`timescale 1ns/1ps
module glue_and_strap_logic_tb_top;
	import glue_pkg::*;
	logic i_clk, i_rst_n, i_supply_on_req, i_supply_good_in, i_panel_button_reset_n;
	logic i_cpu_present_n, i_primary_drive_busy_n, i_secondary_drive_busy_n, i_scsi_drive_busy_n;
	logic i_cfg_base_select_strap, i_float_all_strap_n, i_xor_test_strap_n;
	logic i_shared_gp_port, i_shared_gp_port_oe_n, o_drive_activity_led_n, o_drive_activity_led_oe_n;
	logic o_main_supply_request_n, o_main_supply_request_oe_n, o_system_good_out;
	logic o_system_good_out_oe_n, o_socket_clock_gate, o_socket_clock_gate_oe_n, o_cpu_installed;
	logic o_codec_enable_in, o_shared_gp_port_out, o_shared_gp_port_oe_n, o_straps_valid;
	logic o_xor_tree_out;
	logic [7:0] o_cfg_index_addr, o_cfg_data_addr;
	pin_mode_t o_pin_mode;
	logic [1:0] sel;
	int failures = 0;
	int num_checks = 0;
	glue_and_strap_logic uut (.*);
	board_model board (.i_clk(i_clk), .i_req_n(o_main_supply_request_n), .i_strap_sel(sel),
		.o_supply_good(i_supply_good_in), .o_float_n(i_float_all_strap_n), .o_test_n(i_xor_test_strap_n));
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end
	// ----------
	// Helpers
	// ----------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Tree result over the digital inputs, as the bench last drove them
	function automatic logic xor_in();
		return ^{i_scsi_drive_busy_n, i_secondary_drive_busy_n, i_primary_drive_busy_n,
			i_cpu_present_n, i_panel_button_reset_n, i_supply_good_in, i_shared_gp_port,
			i_supply_on_req};
	endfunction
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Straps settle before release, as the resistors would
	task automatic restart(input logic b, input logic [1:0] s);
		i_rst_n = 1'h0;
		i_cfg_base_select_strap = b;
		sel = s;
		wait_n(16);
		i_rst_n = 1'h1;
		wait_n(6);
	endtask
	task automatic end_of_test();
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic t_drives();
		for (int i = 0; i < 3; i++) begin
			{i_scsi_drive_busy_n, i_secondary_drive_busy_n, i_primary_drive_busy_n} = ~(3'h1 << i);
			wait_n(4);
			chk(o_drive_activity_led_n, 8'h0, "led");
			chk(o_drive_activity_led_oe_n, 8'h0, "led_oe");
			{i_scsi_drive_busy_n, i_secondary_drive_busy_n, i_primary_drive_busy_n} = 3'h7;
			wait_n(4);
			chk(o_drive_activity_led_n, 8'h1, "led");
		end
	endtask
	task automatic t_power();
		i_supply_on_req = 1'h1;
		wait_n(16);
		chk(o_main_supply_request_n, 8'h0, "supply_req");
		chk(o_system_good_out, 8'h1, "good");
		chk(o_socket_clock_gate, 8'h1, "gate");
		chk(o_main_supply_request_oe_n, 8'h0, "supply_oe");
		chk(o_system_good_out_oe_n, 8'h0, "good_oe");
		chk(o_socket_clock_gate_oe_n, 8'h1, "gate_oe");
		i_panel_button_reset_n = 1'h0;
		wait_n(4);
		chk(o_system_good_out, 8'h0, "good");
		i_panel_button_reset_n = 1'h1;
		i_supply_on_req = 1'h0;
		wait_n(8);
		chk(o_main_supply_request_n, 8'h1, "supply_req");
		chk(o_socket_clock_gate, 8'h0, "gate");
		chk(o_main_supply_request_oe_n, 8'h1, "supply_oe");
		chk(o_socket_clock_gate_oe_n, 8'h0, "gate_oe");
	endtask
	task automatic t_misc();
		for (int v = 0; v < 2; v++) begin
			i_cpu_present_n = v[0];
			i_shared_gp_port = v[0];
			i_shared_gp_port_oe_n = v[0];
			wait_n(4);
			chk(o_cpu_installed, {7'h0, ~v[0]}, "cpu");
			chk(o_codec_enable_in, {7'h0, v[0]}, "codec");
			chk(o_shared_gp_port_out, {7'h0, v[0]}, "gp_out");
			chk(o_shared_gp_port_oe_n, {7'h0, v[0]}, "gp_oe");
		end
	endtask
	task automatic t_straps();
		restart(1'h0, 2'h0);
		chk(o_cfg_index_addr, 8'h4E, "index");
		chk(o_cfg_data_addr, 8'h4F, "data");
		chk(o_straps_valid, 8'h1, "valid");
		i_cfg_base_select_strap = 1'h1;
		sel = 2'h1;
		wait_n(4);
		chk(o_cfg_index_addr, 8'h4E, "index");
		chk(o_pin_mode, PIN_NORMAL, "mode");
		i_primary_drive_busy_n = 1'h0;
		i_shared_gp_port_oe_n = 1'h0;
		restart(1'h1, 2'h1);
		chk(o_pin_mode, PIN_FLOAT, "mode");
		chk(o_drive_activity_led_oe_n, 8'h1, "led_oe");
		chk(o_main_supply_request_oe_n, 8'h1, "supply_oe");
		chk(o_system_good_out_oe_n, 8'h1, "good_oe");
		chk(o_socket_clock_gate_oe_n, 8'h1, "gate_oe");
		chk(o_shared_gp_port_oe_n, 8'h1, "gp_oe");
		restart(1'h1, 2'h2);
		chk(o_pin_mode, PIN_XOR_TREE, "mode");
		chk(o_xor_tree_out, {7'h0, xor_in()}, "xor");
		i_primary_drive_busy_n = 1'h1;
		wait_n(4);
		chk(o_xor_tree_out, {7'h0, xor_in()}, "xor");
		restart(1'h1, 2'h0);
		chk(o_cfg_index_addr, 8'h2E, "index");
		chk(o_cfg_data_addr, 8'h2F, "data");
		chk(o_xor_tree_out, 8'h0, "xor");
		chk(o_shared_gp_port_oe_n, 8'h0, "gp_oe");
	endtask
	// Whole run: defaults, reset, then each scenario
	initial begin
		{i_supply_on_req, i_cpu_present_n, i_shared_gp_port, i_shared_gp_port_oe_n} = 4'h7;
		i_panel_button_reset_n = 1'h1;
		{i_scsi_drive_busy_n, i_secondary_drive_busy_n, i_primary_drive_busy_n} = 3'h7;
		restart(1'h1, 2'h0);
		t_drives();
		t_power();
		t_misc();
		t_straps();
		end_of_test();
	end
	// Hang guard, far beyond the 178 cycles the scenarios take
	initial begin
		wait_n(3000);
		failures++;
		end_of_test();
	end
endmodule
